// ==== low_power_mode_control.sv ====
// Low-power mode controller: stop and wait sequencing, wake detection and
// the oscillator stabilisation delay. Assumes the CPU core issues one-cycle
// stop and wait requests, and that the register port master never waits.
// Behaviour
// R1 - Stop enabled sleeps; otherwise chip reset
// R2 - Stop mode turns oscillator off
// R3 - Stop clears pending and disables timer interrupt
// R4 - Stop clears timer prescaler
// R5 - Stop clears I bit, sets irq enable
// R6 - Stop changes nothing else
// R7 - Stop wakes on irq, reset, port, bus
// R8 - Wake holds clock for 4064 cycles
// R9 - Wait stops processor clock
// R10 - Wait keeps timer clocks running
// R11 - Wait clears interrupt mask bit
// R12 - Wait changes nothing else
// R13 - Wait wakes on timer, irq, reset, port, bus
// R14 - Integrator disables stop when watchdog used
// R15 - Output-direction port pins never wake
// R16 - Wake during stabilisation held then serviced
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_control #(
    parameter int STAB_CYCLES = lpm_pkg::STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stop_req,
    input wire logic wait_req,
    input wire logic irq_pin,
    input wire logic ext_reset,
    input wire logic serial_link_bus_pin,
    input wire logic [7:0] port_a_pin,
    input wire logic [7:0] port_c_pin,
    input wire logic timer_irq,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic osc_enable,
    output logic cpu_clk_enable,
    output logic timer_clk_enable,
    output logic wake_service,
    output lpm_pkg::side_effects_s fx
);

    // The counter must reach its last value and still fit its width.
    if (STAB_CYCLES < 2 || STAB_CYCLES >= (1 << lpm_pkg::STAB_W))
    begin
        $error("STAB_CYCLES out of range");
    end

    localparam logic [lpm_pkg::STAB_W-1:0] STAB_LAST =
        lpm_pkg::STAB_W'(STAB_CYCLES - 1);

    lpm_pkg::state_s s;
    lpm_pkg::state_s next_s;

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    // Falling edges count only on input-direction pins; an output pin
    // toggling under software control must never wake the part.
    logic port_fall;
    logic bus_rise;
    logic irq_req;
    logic rst_req;
    logic stop_en;

    always_comb
    begin
        port_fall = |((s.pa_d & ~s.pa_s2) & ~s.dir_a) // R15
            | |((s.pc_d & ~s.pc_s2) & ~s.dir_c); // R15
        bus_rise = s.ext_s2[2] & ~s.bus_d;
        irq_req = s.ext_s2[0];
        rst_req = s.ext_s2[1];
        stop_en = s.ctrl[lpm_pkg::CTRL_STOP_EN_BIT];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.fx = '0;
        next_s.pa_s1 = port_a_pin;
        next_s.pa_s2 = s.pa_s1;
        next_s.pa_d = s.pa_s2;
        next_s.pc_s1 = port_c_pin;
        next_s.pc_s2 = s.pc_s1;
        next_s.pc_d = s.pc_s2;
        next_s.ext_s1 = {serial_link_bus_pin, ext_reset, irq_pin};
        next_s.ext_s2 = s.ext_s1;
        next_s.bus_d = s.ext_s2[2];
        next_s.rdata = 8'h00;

        if (wr)
        begin
            case (addr)
                lpm_pkg::ADDR_CTRL: next_s.ctrl = wdata;
                lpm_pkg::ADDR_DIR_A: next_s.dir_a = wdata;
                lpm_pkg::ADDR_DIR_C: next_s.dir_c = wdata;
                default: next_s.ctrl = s.ctrl;
            endcase
        end
        if (rd)
        begin
            case (addr)
                lpm_pkg::ADDR_CTRL: next_s.rdata = s.ctrl;
                lpm_pkg::ADDR_STATUS: next_s.rdata =
                    {5'h00, s.wake_pend, 2'(s.mode)};
                lpm_pkg::ADDR_DIR_A: next_s.rdata = s.dir_a;
                lpm_pkg::ADDR_DIR_C: next_s.rdata = s.dir_c;
                default: next_s.rdata = 8'h00;
            endcase
        end

        case (s.mode)
            lpm_pkg::RUN:
            begin
                next_s.wake_pend = 1'b0;
                if (stop_req && stop_en)
                begin
                    // Only these side effects; all else untouched. R6
                    next_s.mode = lpm_pkg::STOPPED; // R1
                    next_s.fx.clr_timer_irq = 1'b1; // R3
                    next_s.fx.clr_prescaler = 1'b1; // R4
                    next_s.fx.clr_i_bit = 1'b1; // R5
                    next_s.fx.set_irq_enable = 1'b1; // R5
                end
                else if (stop_req)
                begin
                    next_s.fx.chip_reset = 1'b1; // R1
                end
                else if (wait_req)
                begin
                    next_s.mode = lpm_pkg::WAITING; // R9
                    next_s.fx.clr_i_bit = 1'b1; // R11 R12
                end
            end
            lpm_pkg::STOPPED:
            begin
                if (irq_req || rst_req || port_fall || bus_rise) // R7
                begin
                    next_s.mode = lpm_pkg::STABILISE;
                    next_s.count = '0;
                end
            end
            lpm_pkg::WAITING:
            begin
                if (timer_irq || irq_req || rst_req || port_fall
                    || bus_rise) // R13
                begin
                    next_s.mode = lpm_pkg::RUN;
                end
            end
            lpm_pkg::STABILISE:
            begin
                // Wake sources seen while counting are kept for after.
                if (irq_req || rst_req || port_fall || bus_rise) // R16
                begin
                    next_s.wake_pend = 1'b1;
                end
                if (s.count == STAB_LAST) // R8
                begin
                    next_s.mode = lpm_pkg::RUN;
                end
                else
                begin
                    next_s.count = s.count + 1'b1;
                end
            end
            default: next_s.mode = lpm_pkg::RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.mode <= lpm_pkg::RUN;
            s.ctrl <= lpm_pkg::CTRL_RESET;
            s.dir_a <= lpm_pkg::DIR_RESET;
            s.dir_c <= lpm_pkg::DIR_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The controller itself stays on clk so it can see wake sources; the
    // oscillator enable gates everything else in the chip.
    always_comb
    begin
        rdata = s.rdata;
        fx = s.fx;
        osc_enable = (s.mode != lpm_pkg::STOPPED) // R2
            && (s.mode != lpm_pkg::STABILISE); // R8
        cpu_clk_enable = (s.mode == lpm_pkg::RUN); // R9
        timer_clk_enable = osc_enable; // R10
        wake_service = (s.mode == lpm_pkg::RUN) && s.wake_pend; // R16
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_stop_enter;
        stop_req && stop_en && s.mode == lpm_pkg::RUN;
    endsequence

    property p_stop_or_reset;
        @(posedge clk) disable iff (rst)
        stop_req && !stop_en && s.mode == lpm_pkg::RUN
            |=> fx.chip_reset && cpu_clk_enable;
    endproperty
    a_stop_or_reset: assert property (p_stop_or_reset) // R1
        else $error("disabled stop did not reset");

    property p_osc_off;
        @(posedge clk) disable iff (rst)
        s_stop_enter |=> !osc_enable && !timer_clk_enable;
    endproperty
    a_osc_off: assert property (p_osc_off) // R2
        else $error("oscillator still on in stop");

    property p_stop_fx;
        @(posedge clk) disable iff (rst)
        s_stop_enter |=> fx.clr_timer_irq && fx.clr_prescaler
            && fx.clr_i_bit && fx.set_irq_enable ##1 fx == '0;
    endproperty
    a_stop_fx: assert property (p_stop_fx) // R3
        else $error("stop side effects wrong");

    property p_wait_clk;
        @(posedge clk) disable iff (rst)
        wait_req && !stop_req && s.mode == lpm_pkg::RUN
            |=> !cpu_clk_enable && timer_clk_enable && fx.clr_i_bit
            && !fx.clr_prescaler;
    endproperty
    a_wait_clk: assert property (p_wait_clk) // R9
        else $error("wait clocks wrong");

    property p_wait_exit;
        @(posedge clk) disable iff (rst)
        s.mode == lpm_pkg::WAITING && timer_irq |=> cpu_clk_enable;
    endproperty
    a_wait_exit: assert property (p_wait_exit) // R13
        else $error("wait not left on timer irq");

    property p_stop_hold;
        @(posedge clk) disable iff (rst)
        s.mode == lpm_pkg::STOPPED && !irq_req && !rst_req && !port_fall
            && !bus_rise |=> s.mode == lpm_pkg::STOPPED;
    endproperty
    a_stop_hold: assert property (p_stop_hold) // R7
        else $error("stop left without wake source");

    // Cycles spent stabilising, counted apart from the state so that the
    // delay check does not lean on the counter that it is checking.
    logic [lpm_pkg::STAB_W:0] stab_seen;

    always_ff @(posedge clk)
    begin
        if (rst || s.mode != lpm_pkg::STABILISE)
        begin
            stab_seen <= '0;
        end
        else
        begin
            stab_seen <= stab_seen + 1'b1;
        end
    end

    property p_stab_len;
        @(posedge clk) disable iff (rst)
        $fell(s.mode == lpm_pkg::STABILISE)
            |-> stab_seen == STAB_CYCLES && cpu_clk_enable;
    endproperty
    a_stab_len: assert property (p_stab_len) // R8
        else $error("stabilisation delay wrong");

    property p_stab_bound;
        @(posedge clk) disable iff (rst)
        s.mode == lpm_pkg::STABILISE
            |-> stab_seen < STAB_CYCLES && !cpu_clk_enable;
    endproperty
    a_stab_bound: assert property (p_stab_bound) // R8
        else $error("stabilisation overran its delay");

    property p_stab_count;
        @(posedge clk) disable iff (rst)
        s.mode == lpm_pkg::STABILISE && s.count == STAB_LAST
            |=> cpu_clk_enable;
    endproperty
    a_stab_count: assert property (p_stab_count) // R8
        else $error("delay not ended at last count");

    property p_dir_mask;
        @(posedge clk) disable iff (rst)
        (&s.dir_a) && (&s.dir_c) |-> !port_fall;
    endproperty
    a_dir_mask: assert property (p_dir_mask) // R15
        else $error("output pin caused wake");

    property p_pend;
        @(posedge clk) disable iff (rst)
        s.mode == lpm_pkg::STABILISE && s.count == STAB_LAST && irq_req
            |=> wake_service;
    endproperty
    a_pend: assert property (p_pend) // R16
        else $error("held wake not serviced");

endmodule

`default_nettype wire

// ==== lpm_pkg.sv ====
// Shared constants and carrier types for the low-power mode controller.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package lpm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int STAB_CYCLES = 4064;
    localparam int STAB_W = 12;

    // ------------------------------------------------------------
    // Register bus map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_DIR_A = 4'h2;
    localparam logic [3:0] ADDR_DIR_C = 4'h3;

    // Control register fields.
    localparam int CTRL_STOP_EN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;

    // Status register fields.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_PEND_BIT = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN,
        STOPPED,
        WAITING,
        STABILISE
    } mode_e;

    typedef struct packed {
        logic clr_timer_irq;
        logic clr_prescaler;
        logic clr_i_bit;
        logic set_irq_enable;
        logic chip_reset;
    } side_effects_s;

    typedef struct packed {
        mode_e mode;
        logic [STAB_W-1:0] count;
        logic wake_pend;
        logic [7:0] ctrl;
        logic [7:0] dir_a;
        logic [7:0] dir_c;
        logic [7:0] pa_s1;
        logic [7:0] pa_s2;
        logic [7:0] pa_d;
        logic [7:0] pc_s1;
        logic [7:0] pc_s2;
        logic [7:0] pc_d;
        logic [2:0] ext_s1;
        logic [2:0] ext_s2;
        logic bus_d;
        logic [7:0] rdata;
        side_effects_s fx;
    } state_s;

endpackage

// ==== cpu_core_model.sv ====
// Behavioural CPU core that issues stop and wait instructions on command.
// Assumes it shares clk and the synchronous reset with the controller.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_clk_enable,
    input wire logic want_stop,
    input wire logic want_wait,
    output logic stop_req,
    output logic wait_req
);
    // A halted core executes nothing, so requests need a running clock.
    always_ff @(posedge clk)
    begin
        stop_req <= !rst && want_stop && cpu_clk_enable;
        wait_req <= !rst && want_wait && cpu_clk_enable && !want_stop;
    end
endmodule

`default_nettype wire

// ==== low_power_mode_control_bench.sv ====
// Self-checking bench for the low-power mode controller.
// Assumes the CPU core model drives the stop and wait requests.
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_control_bench;
    localparam int STAB = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic want_stop = 1'b0;
    logic want_wait = 1'b0;
    logic stop_req;
    logic wait_req;
    logic irq_pin = 1'b0;
    logic ext_reset = 1'b0;
    logic serial_link_bus_pin = 1'b0;
    logic [7:0] port_a_pin = 8'hFF;
    logic [7:0] port_c_pin = 8'hFF;
    logic timer_irq = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic osc_enable;
    logic cpu_clk_enable;
    logic timer_clk_enable;
    logic wake_service;
    lpm_pkg::side_effects_s fx;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 32'h8fce;
    int cyc = 0;
    int n;
    int b;
    logic [7:0] v;

    always #10 clk = ~clk;

    cpu_core_model u_cpu (.clk, .rst, .cpu_clk_enable, .want_stop,
        .want_wait, .stop_req, .wait_req);

    low_power_mode_control #(.STAB_CYCLES(STAB)) u_dut (.clk, .rst,
        .stop_req, .wait_req, .irq_pin, .ext_reset, .serial_link_bus_pin,
        .port_a_pin, .port_c_pin, .timer_irq, .addr, .wdata, .wr, .rd,
        .rdata, .osc_enable, .cpu_clk_enable, .timer_clk_enable,
        .wake_service, .fx);

    // Expected side-effect pulses: 0 stop disabled, 1 stop, 2 wait.
    function automatic logic [7:0] fx_exp(input int k);
        return (k == 0) ? 8'h01 : (k == 1) ? 8'h1E : 8'h04;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Issues stop (k=1) or wait (k=2) and checks the cycle after it is taken.
    task automatic sleep(input int k, input int ek);
        @(posedge clk);
        if (k == 1) want_stop <= 1'b1;
        else want_wait <= 1'b1;
        @(posedge clk);
        want_stop <= 1'b0;
        want_wait <= 1'b0;
        @(posedge clk);
        #1 check({3'h0, fx}, fx_exp(ek));
        check({6'h0, osc_enable, timer_clk_enable},
            (ek == 1) ? 8'h00 : 8'h03);
        check({7'h0, cpu_clk_enable}, (ek == 0) ? 8'h01 : 8'h00);
    endtask

    task automatic poke(input int s);
        @(posedge clk);
        case (s)
            0: irq_pin <= 1'b1;
            1: ext_reset <= 1'b1;
            2: serial_link_bus_pin <= 1'b1;
            3: port_a_pin[b] <= 1'b0;
            4: port_c_pin[b] <= 1'b0;
            default: timer_irq <= 1'b1;
        endcase
    endtask

    task automatic calm();
        @(posedge clk);
        {irq_pin, ext_reset, serial_link_bus_pin, timer_irq} <= 4'h0;
        port_a_pin <= 8'hFF;
        port_c_pin <= 8'hFF;
        repeat (4) @(posedge clk);
    endtask

    task automatic till_run(output int cnt);
        cnt = 0;
        #1;
        while (cpu_clk_enable !== 1'b1 && cnt < 200)
        begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        b = ($random(seed) & 32'h7FFF_FFFF) % 8;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++)
        begin
            reg_rd((a == 4) ? 4'hF : 4'(a), v);
            check(v, 8'h00);
        end
        $display("test reset values done");
        sleep(1, 0);
        // Stop is enabled only because this bench never runs the watchdog.
        reg_wr(lpm_pkg::ADDR_CTRL, 8'h01);
        v = 8'($random(seed)) & ~(8'h01 << b);
        reg_wr(lpm_pkg::ADDR_DIR_A, v);
        reg_rd(lpm_pkg::ADDR_DIR_A, v);
        check(v[b], 8'h00);
        $display("test stop disabled done");
        for (int s = 0; s < 5; s++)
        begin
            sleep(1, 1);
            reg_rd(lpm_pkg::ADDR_STATUS, v);
            check(v, 8'h01);
            poke(s);
            till_run(n);
            check(8'(n >= STAB + 2 && n <= STAB + 4), 8'h01);
            check({7'h0, wake_service}, (s < 2) ? 8'h01 : 8'h00);
            calm();
        end
        $display("test stop wake sources done");
        for (int s = 0; s < 6; s++)
        begin
            sleep(2, 2);
            poke(s);
            till_run(n);
            check(8'(n <= 6), 8'h01);
            calm();
        end
        $display("test wait wake sources done");
        reg_wr(lpm_pkg::ADDR_DIR_A, 8'hFF);
        reg_wr(lpm_pkg::ADDR_DIR_C, 8'hFF);
        sleep(1, 1);
        @(posedge clk);
        timer_irq <= 1'b1;
        port_c_pin[b] <= 1'b0;
        repeat (12) @(posedge clk);
        #1 check({7'h0, cpu_clk_enable}, 8'h00);
        calm();
        poke(0);
        @(posedge clk);
        irq_pin <= 1'b0;
        repeat (STAB / 2 + 3) @(posedge clk);
        serial_link_bus_pin <= 1'b1;
        till_run(n);
        check({7'h0, wake_service}, 8'h01);
        calm();
        $display("test refused wake and held wake done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
